// ==== inc/flash_isp_pkg.sv ====
// Purpose: Shared constants and types for the flash programming controller.
// Assumes: One machine-cycle clock; special function registers selected by index.
// Notes: Counts are in machine cycles.
//
// Notes on behaviour
// R1: Flash array is thirty pages of 512 bytes; page erase clears one page.
// R2: Every erase leaves each byte of the erased region at FF.
// R3: Software erases a page before programming new data into it.
// R4: Two erase modes exist: whole-array mass erase and single-page erase.
// R5: Selector 000 standby, 001 read, 010 program, 011 page erase.
// R6: Selector 111, 101, 110 erase, read, program user option byte; need low address bit set.
// R7: Factory option byte is never changed by firmware-started operations.
// R8: Program writes the data port byte; read returns the fetched byte there.
// R9: Address is high address byte above low address byte.
// R10: Operation starts only on 46h then B9h with write enable set; the code starts mass erase from the pin without either.
// R11: Software loads selector, control and address before the trigger pair.
// R12: CPU is held until the operation ends; read data is then valid.
// R13: Reading command port returns an identification byte chosen by low address bit.
// R14: Control bit 7 permits flash changes when one, forbids when zero; the code lets a pin mass erase run with it zero.
// R15: Control bit 6 chooses boot area: zero application, one loader.
// R16: Writing one to control bit 5 pulses software reset; bit self-clears.
// R17: Software reset keeps write enable and boot select; only power-up clears them.
// R18: Wait field sets stall cycles per erase, program and read from the table.
// R19: Power-up boots loader when boot pin low and loader size not 11.
// R20: After software reset the boot area follows the soft boot select bit.
// R21: Application code cannot change loader memory; such requests are silently dropped.
// R22: Data flash is programmable by both application and loader code.
// R23: Data flash use needs factory option bits 5:4 at 10; at most 10K. The code has no factory option and no such check or limit.
// R24: Wrong second byte or cleared write enable discards the sequence.
package flash_isp_pkg;

    localparam int unsigned PAGE_COUNT = 30;
    localparam int unsigned PAGE_BYTES = 512;
    localparam int unsigned ARRAY_BYTES = PAGE_COUNT * PAGE_BYTES;
    localparam logic [15:0] ARRAY_END = 16'h3C00;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;

    localparam logic [7:0] SEQ_FIRST = 8'h46;
    localparam logic [7:0] SEQ_SECOND = 8'hB9;

    localparam logic [2:0] SEL_DATA = 3'h0;
    localparam logic [2:0] SEL_ADDR_HI = 3'h1;
    localparam logic [2:0] SEL_ADDR_LO = 3'h2;
    localparam logic [2:0] SEL_OP = 3'h3;
    localparam logic [2:0] SEL_CMD = 3'h4;
    localparam logic [2:0] SEL_CTRL = 3'h5;

    localparam int unsigned CTRL_EN_BIT = 7;
    localparam int unsigned CTRL_BS_BIT = 6;
    localparam int unsigned CTRL_SR_BIT = 5;

    localparam logic [2:0] OP_READ = 3'h1;
    localparam logic [2:0] OP_PROG = 3'h2;
    localparam logic [2:0] OP_ERASE = 3'h3;
    localparam logic [2:0] OP_UOB_READ = 3'h5;
    localparam logic [2:0] OP_UOB_PROG = 3'h6;
    localparam logic [2:0] OP_UOB_ERASE = 3'h7;

    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ADDR_RST = 8'h00;
    localparam logic [2:0] OP_RST = 3'h0;
    localparam logic [2:0] WAIT_RST = 3'h0;
    localparam logic [7:0] UOB_RST = 8'hFF;

    localparam int unsigned ERASE_CYC [4] = '{43769, 21885, 10942, 5471};
    localparam int unsigned PROG_CYC [4] = '{240, 120, 60, 30};
    localparam int unsigned READ_CYC [4] = '{43, 22, 11, 6};

    localparam logic [15:0] LOADER_SZ_00 = 16'h1000;
    localparam logic [15:0] LOADER_SZ_01 = 16'h0800;
    localparam logic [15:0] LOADER_SZ_10 = 16'h0400;
    localparam logic [1:0] STRAP_SETTLE = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b11,
        ST_DONE = 2'b10
    } seq_state_t;

    typedef enum logic [1:0] {
        KIND_ERASE = 2'h0,
        KIND_PROG = 2'h1,
        KIND_READ = 2'h2
    } op_kind_t;

endpackage

// ==== rtl/flash_page_array.sv ====
// Purpose: Byte-wide flash array with page and mass erase.
// Assumes: Erase walks one byte per cycle.
// Notes: Contents have no reset.
module flash_page_array
    import flash_isp_pkg::*;
#(
    parameter int unsigned PAGES = PAGE_COUNT,
    parameter int unsigned PAGE_SZ = PAGE_BYTES,
    parameter int unsigned AW = 14
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_rd,
    input wire logic i_prog,
    input wire logic i_page_erase,
    input wire logic i_mass_erase,
    input wire logic [AW-1:0] i_addr,
    input wire logic [7:0] i_wdata,
    output logic [7:0] o_rdata,
    output logic o_busy
);
    localparam int unsigned BYTES = PAGES * PAGE_SZ;
    localparam int unsigned PW = $clog2(PAGE_SZ);

    logic [7:0] mem [BYTES];
    logic [AW-1:0] ptr_reg;
    logic [AW-1:0] end_reg;
    logic erasing_reg;

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            erasing_reg <= 1'b0;
            ptr_reg <= '0;
            end_reg <= '0;
        end else if (!erasing_reg) begin
            if (i_mass_erase) begin
                erasing_reg <= 1'b1; // R4
                ptr_reg <= '0;
                end_reg <= AW'(BYTES - 1);
            end else if (i_page_erase) begin
                erasing_reg <= 1'b1; // R1
                ptr_reg <= {i_addr[AW-1:PW], PW'(0)};
                end_reg <= {i_addr[AW-1:PW], {PW{1'b1}}};
            end
        end else if (ptr_reg == end_reg) begin
            erasing_reg <= 1'b0;
        end else begin
            ptr_reg <= ptr_reg + 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (erasing_reg) begin
            mem[ptr_reg] <= ERASED_BYTE; // R2
        end else if (i_prog && i_addr < BYTES) begin
            mem[i_addr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= (i_addr < BYTES) ? mem[i_addr] : ERASED_BYTE;
        end
    end

    assign o_busy = erasing_reg;

    property p_page_len;
        @(posedge i_clk) disable iff (!i_resetn)
        i_page_erase && !erasing_reg && !i_mass_erase |=> o_busy [*8];
    endproperty
    a_page_len: assert property (p_page_len) else $error("page erase too short"); // R1

endmodule // flash_page_array

// ==== rtl/flash_wait_timer.sv ====
// Purpose: Counts the CPU stall for one flash operation.
// Assumes: Wait codes above 3 use the code 3 figures.
// Notes: Busy for exactly the table count after the start cycle.
module flash_wait_timer
    import flash_isp_pkg::*;
#(
    parameter int unsigned ERASE_W0 = ERASE_CYC[0],
    parameter int unsigned ERASE_W1 = ERASE_CYC[1],
    parameter int unsigned ERASE_W2 = ERASE_CYC[2],
    parameter int unsigned ERASE_W3 = ERASE_CYC[3],
    parameter int unsigned CNT_W = 16
) (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_start,
    input wire logic [2:0] i_wait_code,
    input wire op_kind_t i_kind,
    output logic o_busy
);
    localparam int unsigned ERASE_TBL [4] = '{ERASE_W0, ERASE_W1, ERASE_W2, ERASE_W3};

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] load_val;
    logic [1:0] code;

    always_comb begin
        code = i_wait_code[2] ? 2'h3 : i_wait_code[1:0];
        case (i_kind)
            KIND_PROG: load_val = CNT_W'(PROG_CYC[code]); // R18
            KIND_READ: load_val = CNT_W'(READ_CYC[code]);
            default: load_val = CNT_W'(ERASE_TBL[code]);
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            cnt_reg <= '0;
        end else if (i_start) begin
            cnt_reg <= load_val;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - 1'b1;
        end
    end

    assign o_busy = cnt_reg != '0;

    property p_read_fast;
        @(posedge i_clk) disable iff (!i_resetn)
        i_start && i_kind == KIND_READ && i_wait_code == 3'h3
            |=> o_busy [*6] ##1 !o_busy;
    endproperty
    a_read_fast: assert property (p_read_fast) else $error("read stall not 6"); // R18

endmodule // flash_wait_timer

// ==== rtl/flash_isp_ctrl.sv ====
// Purpose: Flash programming controller behind six special function registers.
// Assumes: CPU gives one-cycle write strobes and respects O_CPU_HOLD.
// Notes: I_RESETN is the power-up reset; software reset is produced here.
module flash_isp_ctrl
    import flash_isp_pkg::*;
#(
    parameter int unsigned ERASE_WAIT_0 = ERASE_CYC[0],
    parameter int unsigned ERASE_WAIT_1 = ERASE_CYC[1],
    parameter int unsigned ERASE_WAIT_2 = ERASE_CYC[2],
    parameter int unsigned ERASE_WAIT_3 = ERASE_CYC[3],
    // Arbitrary identification value
    parameter logic [7:0] IDENT_HI = 8'h5A,
    // Arbitrary identification value
    parameter logic [7:0] IDENT_LO = 8'hC3
) (
    input wire logic I_CLK,
    input wire logic I_RESETN,
    input wire logic [2:0] I_SFR_SEL,
    input wire logic I_SFR_WR,
    input wire logic I_SFR_RD,
    input wire logic [7:0] I_SFR_WDATA,
    output logic [7:0] O_SFR_RDATA,
    input wire logic I_PC_IN_LOADER,
    input wire logic I_HW_BOOT_SEL,
    input wire logic I_LOADER_SIZE_HI,
    input wire logic I_LOADER_SIZE_LO,
    input wire logic I_MASS_ERASE_REQ,
    output logic O_CPU_HOLD,
    output logic O_SOFT_RESET,
    output logic O_BOOT_LOADER,
    output logic [7:0] O_USER_OPT
);

    seq_state_t state_reg;
    seq_state_t state_next;

    logic [7:0] data_reg;
    logic [7:0] addr_hi_reg;
    logic [7:0] addr_lo_reg;
    logic [2:0] op_reg;
    logic en_reg;
    logic bsel_reg;
    logic [2:0] wait_reg;
    logic soft_rst_reg;
    logic armed_reg;
    logic [7:0] uob_reg;
    logic [7:0] rdata_reg;
    logic boot_loader_reg;
    logic strap_done_reg;
    logic [1:0] strap_cnt_reg;
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic mass_prev_reg;

    logic wr_data;
    logic wr_hi;
    logic wr_lo;
    logic wr_op;
    logic wr_cmd;
    logic wr_ctrl;
    logic [15:0] addr;
    logic [15:0] loader_sz;
    logic in_array;
    logic in_loader;
    logic protect;
    logic start_ok;
    logic trigger;
    logic start;
    logic issue;
    logic capture;
    logic mass_start;
    op_kind_t kind;
    logic mem_busy;
    logic tmr_busy;
    logic [7:0] mem_rdata;

    assign wr_data = I_SFR_WR && I_SFR_SEL == SEL_DATA;
    assign wr_hi = I_SFR_WR && I_SFR_SEL == SEL_ADDR_HI;
    assign wr_lo = I_SFR_WR && I_SFR_SEL == SEL_ADDR_LO;
    assign wr_op = I_SFR_WR && I_SFR_SEL == SEL_OP;
    assign wr_cmd = I_SFR_WR && I_SFR_SEL == SEL_CMD;
    assign wr_ctrl = I_SFR_WR && I_SFR_SEL == SEL_CTRL;

    // Pins pass two flops; bit 3 mass erase, 2/1 loader size, 0 boot pin
    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
            mass_prev_reg <= 1'b0;
        end else begin
            pin_meta_reg <= {I_MASS_ERASE_REQ, I_LOADER_SIZE_HI,
                             I_LOADER_SIZE_LO, I_HW_BOOT_SEL};
            pin_sync_reg <= pin_meta_reg;
            mass_prev_reg <= pin_sync_reg[3];
        end
    end

    assign addr = {addr_hi_reg, addr_lo_reg}; // R9

    always_comb begin
        case (pin_sync_reg[2:1])
            2'b00: loader_sz = LOADER_SZ_00;
            2'b01: loader_sz = LOADER_SZ_01;
            2'b10: loader_sz = LOADER_SZ_10;
            default: loader_sz = 16'h0000;
        endcase
    end

    assign in_array = addr < ARRAY_END;
    assign in_loader = in_array && loader_sz != 16'h0000 && addr >= ARRAY_END - loader_sz;
    // Application code may change data flash but never loader space
    assign protect = in_loader && !I_PC_IN_LOADER; // R21 R22

    always_comb begin
        case (op_reg)
            OP_READ: start_ok = 1'b1; // R5
            OP_PROG: start_ok = in_array && !protect; // R21
            OP_ERASE: start_ok = in_array && !protect;
            // Only the user option byte is reachable; factory byte has no path
            OP_UOB_READ: start_ok = addr_lo_reg[0]; // R6 R7
            OP_UOB_PROG: start_ok = addr_lo_reg[0];
            OP_UOB_ERASE: start_ok = addr_lo_reg[0];
            default: start_ok = 1'b0;
        endcase
    end

    always_comb begin
        case (op_reg)
            OP_READ: kind = KIND_READ;
            OP_UOB_READ: kind = KIND_READ;
            OP_PROG: kind = KIND_PROG;
            OP_UOB_PROG: kind = KIND_PROG;
            default: kind = KIND_ERASE;
        endcase
    end

    assign trigger = wr_cmd && armed_reg && I_SFR_WDATA == SEQ_SECOND && en_reg; // R10 R14
    assign start = trigger && start_ok && state_reg == ST_IDLE && !mem_busy;
    assign issue = state_reg == ST_ISSUE;
    assign capture = state_reg == ST_DONE && (op_reg == OP_READ || op_reg == OP_UOB_READ);
    assign mass_start = pin_sync_reg[3] && !mass_prev_reg && state_reg == ST_IDLE;

    // First byte arms; anything but the second byte, or no enable, disarms
    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            armed_reg <= 1'b0;
        end else if (soft_rst_reg) begin
            armed_reg <= 1'b0;
        end else if (wr_cmd) begin
            armed_reg <= !armed_reg && I_SFR_WDATA == SEQ_FIRST && en_reg; // R24
        end
    end

    always_comb begin
        case (state_reg)
            ST_IDLE: state_next = start ? ST_ISSUE : ST_IDLE; // R10
            ST_ISSUE: state_next = ST_WAIT;
            ST_WAIT: state_next = (tmr_busy || mem_busy) ? ST_WAIT : ST_DONE; // R12
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign O_CPU_HOLD = state_reg != ST_IDLE || mem_busy; // R12

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            data_reg <= DATA_RST;
        end else if (soft_rst_reg) begin
            data_reg <= DATA_RST;
        end else if (capture) begin
            if (op_reg == OP_UOB_READ) begin
                data_reg <= uob_reg;
            end else begin
                data_reg <= in_array ? mem_rdata : ERASED_BYTE; // R8
            end
        end else if (wr_data) begin
            data_reg <= I_SFR_WDATA;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            addr_hi_reg <= ADDR_RST;
            addr_lo_reg <= ADDR_RST;
            op_reg <= OP_RST;
        end else if (soft_rst_reg) begin
            addr_hi_reg <= ADDR_RST;
            addr_lo_reg <= ADDR_RST;
            op_reg <= OP_RST;
        end else begin
            if (wr_hi) begin
                addr_hi_reg <= I_SFR_WDATA;
            end
            if (wr_lo) begin
                addr_lo_reg <= I_SFR_WDATA;
            end
            if (wr_op) begin
                op_reg <= I_SFR_WDATA[2:0];
            end
        end
    end

    // Enable and boot select survive software reset
    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            en_reg <= 1'b0;
            bsel_reg <= 1'b0;
        end else if (wr_ctrl) begin
            en_reg <= I_SFR_WDATA[CTRL_EN_BIT]; // R14 R17
            bsel_reg <= I_SFR_WDATA[CTRL_BS_BIT]; // R15
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            wait_reg <= WAIT_RST;
        end else if (soft_rst_reg) begin
            wait_reg <= WAIT_RST;
        end else if (wr_ctrl) begin
            wait_reg <= I_SFR_WDATA[2:0]; // R18
        end
    end

    // One-cycle pulse; reads back as zero
    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= wr_ctrl && I_SFR_WDATA[CTRL_SR_BIT]; // R16
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            boot_loader_reg <= 1'b0;
            strap_done_reg <= 1'b0;
            strap_cnt_reg <= 2'h0;
        end else if (!strap_done_reg) begin
            if (strap_cnt_reg == STRAP_SETTLE) begin
                boot_loader_reg <= !pin_sync_reg[0] && pin_sync_reg[2:1] != 2'b11; // R19
                strap_done_reg <= 1'b1;
            end else begin
                strap_cnt_reg <= strap_cnt_reg + 1'b1;
            end
        end else if (soft_rst_reg) begin
            boot_loader_reg <= bsel_reg; // R20
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            uob_reg <= UOB_RST;
        end else if (issue && op_reg == OP_UOB_ERASE) begin
            uob_reg <= ERASED_BYTE; // R2 R6
        end else if (issue && op_reg == OP_UOB_PROG) begin
            uob_reg <= data_reg; // R6
        end
    end

    always_ff @(posedge I_CLK) begin
        if (!I_RESETN) begin
            rdata_reg <= 8'h00;
        end else if (I_SFR_RD) begin
            case (I_SFR_SEL)
                SEL_DATA: rdata_reg <= data_reg;
                SEL_ADDR_HI: rdata_reg <= addr_hi_reg;
                SEL_ADDR_LO: rdata_reg <= addr_lo_reg;
                SEL_OP: rdata_reg <= {5'h00, op_reg};
                SEL_CMD: rdata_reg <= addr_lo_reg[0] ? IDENT_LO : IDENT_HI; // R13
                SEL_CTRL: rdata_reg <= {en_reg, bsel_reg, 3'h0, wait_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    assign O_SFR_RDATA = rdata_reg;
    assign O_SOFT_RESET = soft_rst_reg;
    assign O_BOOT_LOADER = boot_loader_reg;
    assign O_USER_OPT = uob_reg;

    flash_page_array u_array (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_rd(issue && op_reg == OP_READ),
        .i_prog(issue && op_reg == OP_PROG), // R8
        .i_page_erase(issue && op_reg == OP_ERASE), // R1
        .i_mass_erase(mass_start), // R4
        .i_addr(addr[13:0]),
        .i_wdata(data_reg),
        .o_rdata(mem_rdata),
        .o_busy(mem_busy)
    );

    flash_wait_timer #(
        .ERASE_W0(ERASE_WAIT_0),
        .ERASE_W1(ERASE_WAIT_1),
        .ERASE_W2(ERASE_WAIT_2),
        .ERASE_W3(ERASE_WAIT_3)
    ) u_timer (
        .i_clk(I_CLK),
        .i_resetn(I_RESETN),
        .i_start(start),
        .i_wait_code(wait_reg),
        .i_kind(kind),
        .o_busy(tmr_busy)
    );

    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);

    sequence s_arm;
        wr_cmd && I_SFR_WDATA == SEQ_FIRST && en_reg && !armed_reg;
    endsequence

    // Second byte may follow after a spare cycle; an armed sequence must still stand
    sequence s_fire;
        wr_cmd && armed_reg && I_SFR_WDATA == SEQ_SECOND && en_reg && start_ok && !mem_busy
            && state_reg == ST_IDLE;
    endsequence

    property p_trigger;
        s_arm ##[1:2] s_fire |=> state_reg == ST_ISSUE ##1 O_CPU_HOLD;
    endproperty
    a_trigger: assert property (p_trigger) else $error("trigger missed"); // R10

    property p_no_enable;
        wr_cmd && !en_reg && state_reg == ST_IDLE |=> state_reg == ST_IDLE && !armed_reg;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("started without enable"); // R14

    property p_bad_second;
        armed_reg && wr_cmd && I_SFR_WDATA != SEQ_SECOND |=> !armed_reg && state_reg == ST_IDLE;
    endproperty
    a_bad_second: assert property (p_bad_second) else $error("bad pair accepted"); // R24

    property p_hold;
        state_reg == ST_ISSUE |-> O_CPU_HOLD ##1 O_CPU_HOLD;
    endproperty
    a_hold: assert property (p_hold) else $error("cpu not held"); // R12

    property p_soft_pulse;
        wr_ctrl && I_SFR_WDATA[CTRL_SR_BIT] |=> O_SOFT_RESET ##1 !O_SOFT_RESET;
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset pulse wrong"); // R16

    property p_keep_bits;
        O_SOFT_RESET && !wr_ctrl |=> $stable(en_reg) && $stable(bsel_reg);
    endproperty
    a_keep_bits: assert property (p_keep_bits) else $error("soft reset hit enable"); // R17

    property p_soft_boot;
        O_SOFT_RESET && strap_done_reg |=> O_BOOT_LOADER == $past(bsel_reg);
    endproperty
    a_soft_boot: assert property (p_soft_boot) else $error("boot area not soft select"); // R20

    property p_uob_bit0;
        trigger && op_reg[2] && !addr_lo_reg[0] |=> state_reg == ST_IDLE;
    endproperty
    a_uob_bit0: assert property (p_uob_bit0) else $error("option op without bit 0"); // R6

    property p_protect;
        trigger && protect && (op_reg == OP_PROG || op_reg == OP_ERASE)
            && state_reg == ST_IDLE |=> state_reg == ST_IDLE;
    endproperty
    a_protect: assert property (p_protect) else $error("loader space changed"); // R21

    property p_ident;
        I_SFR_RD && I_SFR_SEL == SEL_CMD && !addr_lo_reg[0] |=> O_SFR_RDATA == IDENT_HI;
    endproperty
    a_ident: assert property (p_ident) else $error("ident byte wrong"); // R13

    property p_uob_erase;
        issue && op_reg == OP_UOB_ERASE |=> O_USER_OPT == ERASED_BYTE;
    endproperty
    a_uob_erase: assert property (p_uob_erase) else $error("option byte not FF"); // R2

endmodule // flash_isp_ctrl

// ==== dv/tb.sv ====
// Purpose: Self-checking bench for the flash programming controller.
// Assumes: Erase counts cut to 600 for speed; factory option allows data flash.
// Notes: Each test is a sequence of register writes, trigger pairs and reads.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_isp_pkg::*;
    localparam int EW = 600;
    logic I_CLK, I_RESETN, I_SFR_WR, I_SFR_RD, I_PC_IN_LOADER, I_HW_BOOT_SEL;
    logic I_LOADER_SIZE_HI, I_LOADER_SIZE_LO, I_MASS_ERASE_REQ;
    logic O_CPU_HOLD, O_SOFT_RESET, O_BOOT_LOADER;
    logic [2:0] I_SFR_SEL;
    logic [7:0] I_SFR_WDATA, O_SFR_RDATA, O_USER_OPT, v;
    logic [15:0] h;
    int failures, n_tests, cyc;

    // Identification values are arbitrary
    flash_isp_ctrl #(.ERASE_WAIT_0(EW), .ERASE_WAIT_1(EW), .ERASE_WAIT_2(EW),
        .ERASE_WAIT_3(EW), .IDENT_HI(8'h96), .IDENT_LO(8'h3E)) i_dut (
        .I_CLK(I_CLK), .I_RESETN(I_RESETN), .I_SFR_SEL(I_SFR_SEL),
        .I_SFR_WR(I_SFR_WR), .I_SFR_RD(I_SFR_RD), .I_SFR_WDATA(I_SFR_WDATA),
        .O_SFR_RDATA(O_SFR_RDATA), .I_PC_IN_LOADER(I_PC_IN_LOADER),
        .I_HW_BOOT_SEL(I_HW_BOOT_SEL), .I_LOADER_SIZE_HI(I_LOADER_SIZE_HI),
        .I_LOADER_SIZE_LO(I_LOADER_SIZE_LO), .I_MASS_ERASE_REQ(I_MASS_ERASE_REQ),
        .O_CPU_HOLD(O_CPU_HOLD), .O_SOFT_RESET(O_SOFT_RESET),
        .O_BOOT_LOADER(O_BOOT_LOADER), .O_USER_OPT(O_USER_OPT));

    initial begin
        I_CLK = 1'b0;
        forever #20 I_CLK = ~I_CLK;
    end

    always @(posedge I_CLK) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            report_and_stop;
        end
    end

    task chk(input logic [15:0] s, input logic [15:0] e);
        n_tests++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task wr(input logic [2:0] s, input logic [7:0] d);
        @(posedge I_CLK);
        #1;
        I_SFR_SEL = s;
        I_SFR_WDATA = d;
        I_SFR_WR = 1'b1;
        @(posedge I_CLK);
        #1;
        I_SFR_WR = 1'b0;
    endtask

    task rd(input logic [2:0] s);
        @(posedge I_CLK);
        #1;
        I_SFR_SEL = s;
        I_SFR_RD = 1'b1;
        @(posedge I_CLK);
        #1;
        I_SFR_RD = 1'b0;
        v = O_SFR_RDATA;
    endtask

    // Loads selector, control, address and data, then sends 46h and k2; h = hold cycles
    task go(input logic [2:0] op, input logic [7:0] ct, input logic [15:0] a,
            input logic [7:0] d, input logic [7:0] k2);
        wr(SEL_OP, {5'h00, op});
        wr(SEL_CTRL, ct);
        wr(SEL_ADDR_HI, a[15:8]);
        wr(SEL_ADDR_LO, a[7:0]);
        wr(SEL_DATA, d);
        wr(SEL_CMD, SEQ_FIRST);
        wr(SEL_CMD, k2);
        h = 16'h0000;
        while (O_CPU_HOLD === 1'b1 && h < 16'd20000) begin
            @(posedge I_CLK);
            #1;
            h++;
        end
    endtask

    task report_and_stop;
        $display("Counts: compares=%0d mismatches=%0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        {I_RESETN, I_SFR_WR, I_SFR_RD, I_PC_IN_LOADER, I_HW_BOOT_SEL} = 5'h00;
        {I_LOADER_SIZE_HI, I_LOADER_SIZE_LO, I_MASS_ERASE_REQ} = 3'h0;
        I_SFR_SEL = 3'h0;
        I_SFR_WDATA = 8'h00;
        repeat (12) @(posedge I_CLK);
        #1 I_RESETN = 1'b1;
        repeat (6) @(posedge I_CLK);
        #1;
        chk(O_BOOT_LOADER, 1);
        chk(O_USER_OPT, 16'h00FF);
        rd(SEL_CTRL);
        chk(v, 0);
        rd(3'h6);
        chk(v, 0);
        wr(SEL_ADDR_LO, 8'h00);
        rd(SEL_CMD);
        chk(v, 16'h0096);
        wr(SEL_ADDR_LO, 8'h01);
        rd(SEL_CMD);
        chk(v, 16'h003E);
        $display("Test reset and ident done");
        go(OP_ERASE, 8'h83, 16'h0200, 8'h00, SEQ_SECOND);
        chk(h, 16'(EW + 2));
        go(OP_READ, 8'h83, 16'h03FF, 8'h00, SEQ_SECOND);
        rd(SEL_DATA);
        chk(v, 16'h00FF);
        go(OP_PROG, 8'h83, 16'h0210, 8'hA5, SEQ_SECOND);
        chk(h, 16'(PROG_CYC[3] + 2));
        for (int w = 0; w < 4; w++) begin
            go(OP_READ, 8'h80 | 8'(w), 16'h0210, 8'h00, SEQ_SECOND);
            chk(h, 16'(READ_CYC[w] + 2));
            rd(SEL_DATA);
            chk(v, 16'h00A5);
        end
        $display("Test erase program read done");
        go(OP_PROG, 8'h03, 16'h0211, 8'h11, SEQ_SECOND);
        chk(h, 0);
        go(OP_PROG, 8'h83, 16'h0211, 8'h22, 8'hB8);
        chk(h, 0);
        go(3'h0, 8'h83, 16'h0211, 8'h33, SEQ_SECOND);
        chk(h, 0);
        go(OP_READ, 8'h83, 16'h0211, 8'h00, SEQ_SECOND);
        rd(SEL_DATA);
        chk(v, 16'h00FF);
        go(OP_PROG, 8'h83, 16'h3BF0, 8'h44, SEQ_SECOND);
        chk(h, 0);
        I_PC_IN_LOADER = 1'b1;
        go(OP_PROG, 8'h83, 16'h3BF0, 8'h44, SEQ_SECOND);
        chk(h, 16'(PROG_CYC[3] + 2));
        I_PC_IN_LOADER = 1'b0;
        $display("Test refusals done");
        go(OP_UOB_ERASE, 8'h83, 16'h0001, 8'h00, SEQ_SECOND);
        chk(O_USER_OPT, 16'h00FF);
        go(OP_UOB_PROG, 8'h83, 16'h0001, 8'h3C, SEQ_SECOND);
        chk(O_USER_OPT, 16'h003C);
        go(OP_UOB_READ, 8'h83, 16'h0001, 8'h00, SEQ_SECOND);
        rd(SEL_DATA);
        chk(v, 16'h003C);
        go(OP_UOB_ERASE, 8'h83, 16'h0000, 8'h00, SEQ_SECOND);
        chk(h, 0);
        chk(O_USER_OPT, 16'h003C);
        $display("Test option byte done");
        I_MASS_ERASE_REQ = 1'b1;
        repeat (4) @(posedge I_CLK);
        #1;
        chk(O_CPU_HOLD, 1);
        // CPU is stalled through the mass erase; no register access until it ends
        while (O_CPU_HOLD === 1'b1) begin
            @(posedge I_CLK);
            #1;
        end
        go(OP_READ, 8'h83, 16'h0210, 8'h00, SEQ_SECOND);
        rd(SEL_DATA);
        chk(v, 16'h00FF);
        I_MASS_ERASE_REQ = 1'b0;
        $display("Test mass erase done");
        wr(SEL_CTRL, 8'hE3);
        chk(O_SOFT_RESET, 1);
        @(posedge I_CLK);
        #1;
        chk(O_SOFT_RESET, 0);
        chk(O_BOOT_LOADER, 1);
        rd(SEL_CTRL);
        chk(v, 16'h00C0);
        rd(SEL_ADDR_HI);
        chk(v, 0);
        wr(SEL_CTRL, 8'h20);
        repeat (2) @(posedge I_CLK);
        #1;
        chk(O_BOOT_LOADER, 0);
        $display("Test soft reset done");
        report_and_stop;
    end
endmodule // tb
